//--- bmpc_pkg.sv
// Constants and types for the burst mode and protection controller
// What this block does
// - Current-sense over limit drops the gate request in the same switching cycle.
// - Peak current limit and zero-crossing count follow the line-sense level.
// - Two burst levels: level 1 when sampled feedback is above reference, else level 2.
// - Burst current limit 0.31 V or 0.35 V; leave threshold 2.75 V for both levels.
// - Burst entry threshold 0.90 V for level 1, 1.05 V for level 2.
// - Below 4 V supply, supply-good stays low and holds level latch cleared.
// - Latch clear and device off: pull-up disconnected, selection current source on.
// - At supply turn-on, sample feedback, choose level, set the level latch.
// - Once latched, the chosen burst level holds until the supply falls below 4 V and clears the latch.
// - Two microseconds after turn-on, selection source off and pull-up reconnected.
// - Burst set after entry conditions hold continuously for 20 ms.
// - Burst halted: resume switching when feedback rises above burst-on threshold.
// - Burst switching: gate on at fixed 8 (low line) or 10 (high line) crossings.
// - Burst switching: gate off when sense reaches the selected burst current limit.
// - Burst: feedback at burst-off threshold halts switching until it rises again.
// - Feedback above leave threshold clears burst, normal peak-current control resumes.
// - Leaving burst loads up/down counter with 1 (low line) or 3 (high line).
// - Three protection responses: non-switching, odd-skip and plain auto restart.
// - Over-load only in normal mode; supply OV, output OV, sense short not while halted.
// - Line over-voltage enters above threshold, releases below it.
// - Brownout enters below brownout threshold, releases above brown-in threshold.
// - Up/down counter limited to 1..8 low line or 3..10 high line.
// - Zero-crossing counter counts falling crossings after turn-off, clears at gate high.
package bmpc_pkg;
   localparam int      CLK_HZ            = 10_000_000;
   localparam int      SEL_OFF_NS        = 2000;
   localparam int      SEL_OFF_CYC       = (SEL_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int      ENTRY_BLANK_MS    = 20;
   localparam int      ENTRY_BLANK_CYC   = ENTRY_BLANK_MS * (CLK_HZ / 1000);
   localparam logic [3:0] UD_MIN_LOW     = 4'h1;
   localparam logic [3:0] UD_MIN_HIGH    = 4'h3;
   localparam logic [3:0] UD_MAX_LOW     = 4'h8;
   localparam logic [3:0] UD_MAX_HIGH    = 4'hA;
   localparam logic [3:0] ZC_ZERO        = 4'h0;
   localparam logic [3:0] ZC_ONE         = 4'h1;
   // Threshold selector codes for the analog front end
   localparam logic [1:0] SEL_NORMAL     = 2'h0;
   localparam logic [1:0] SEL_BURST_ONE  = 2'h1;
   localparam logic [1:0] SEL_BURST_TWO  = 2'h2;
   // Protection response codes
   localparam logic [1:0] PROT_NONE      = 2'h0;
   localparam logic [1:0] PROT_NOSWITCH  = 2'h1;
   localparam logic [1:0] PROT_ODDSKIP   = 2'h2;
   localparam logic [1:0] PROT_RESTART   = 2'h3;
   typedef enum logic [1:0] {BM_NORMAL, BM_BURST_ON, BM_BURST_OFF} bmpc_mode_t;
endpackage

//--- bmpc_sync.sv
// Two-flop synchroniser bank for comparator inputs
`timescale 1ns/1ps
module bmpc_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

//--- bmpc_ctrl.sv
// Burst mode, current limit and line protection control
`timescale 1ns/1ps
module bmpc_ctrl
   import bmpc_pkg::*;
#(
   // Entry blanking length in cycles; a short value lets a bench reach burst mode
   parameter int BLANK_CYC = ENTRY_BLANK_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       supply_above_4v,
   input  wire logic       supply_on,
   input  wire logic       fb_above_level_ref,
   input  wire logic       fb_below_entry,
   input  wire logic       fb_above_burst_on,
   input  wire logic       fb_below_burst_off,
   input  wire logic       fb_above_leave,
   input  wire logic       cs_above_limit,
   input  wire logic       cs_above_burst_limit,
   input  wire logic       zero_cross_input,
   input  wire logic       high_line,
   input  wire logic       line_above_ovp,
   input  wire logic       line_below_brownout,
   input  wire logic       line_above_brownin,
   input  wire logic       normal_gate_on_req,
   input  wire logic       ud_up,
   input  wire logic       ud_down,
   input  wire logic       ud_reset,
   input  wire logic       fault_vcc_ov,
   input  wire logic       fault_vcc_uv,
   input  wire logic       fault_over_load,
   input  wire logic       fault_out_ov,
   input  wire logic       fault_over_temp,
   input  wire logic       fault_cs_short,
   output logic            gate_on,
   output logic            supply_good,
   output logic            level_latched,
   output logic            burst_level_two,
   output logic            feedback_pullup_en,
   output logic            sel_current_en,
   output logic [1:0]      threshold_sel,
   output logic            line_compensation_high,
   output logic [3:0]      updown_count,
   output logic [3:0]      zero_crossing_count,
   output bmpc_mode_t      burst_mode,
   output logic            line_ovp_active,
   output logic            brownout_active,
   output logic [1:0]      protection_mode
);
   localparam int NS = 18;

   logic [NS-1:0] raw_vec;
   logic [NS-1:0] s_vec;
   logic          s_above_4v, s_on, s_fb_ref, s_fb_entry, s_fb_bon, s_fb_boff, s_fb_leave;
   logic          s_cs_lim, s_cs_blim, s_zc, s_hl, s_lovp, s_bo, s_bi;
   logic          s_nreq, s_up, s_down, s_udr;
   logic          s_on_d_reg;
   logic          zc_d_reg;
   logic [4:0]    sel_cnt_reg;
   logic [24:0]   blank_cnt_reg;
   logic [3:0]    ud_min, ud_max;
   logic          entry_ok, zc_fall, halted, on_req, gate_next;
   logic          chk_odd, chk_ol, odd_fault, ns_fault;

   assign raw_vec = {supply_above_4v, supply_on, fb_above_level_ref, fb_below_entry, fb_above_burst_on,
                     fb_below_burst_off, fb_above_leave, cs_above_limit, cs_above_burst_limit,
                     zero_cross_input, high_line, line_above_ovp, line_below_brownout,
                     line_above_brownin, normal_gate_on_req, ud_up, ud_down, ud_reset};

   bmpc_sync #(.W(NS)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (raw_vec),
      .q       (s_vec)
   );

   assign {s_above_4v, s_on, s_fb_ref, s_fb_entry, s_fb_bon, s_fb_boff, s_fb_leave, s_cs_lim, s_cs_blim,
           s_zc, s_hl, s_lovp, s_bo, s_bi, s_nreq, s_up, s_down, s_udr} = s_vec;

   assign ud_min  = s_hl ? UD_MIN_HIGH : UD_MIN_LOW;
   assign ud_max  = s_hl ? UD_MAX_HIGH : UD_MAX_LOW;
   assign zc_fall = zc_d_reg & ~s_zc;
   assign halted  = (burst_mode == BM_BURST_OFF);

   assign entry_ok = s_fb_entry && (updown_count == ud_max);

   assign chk_ol    = (burst_mode == BM_NORMAL);
   assign chk_odd   = !halted;
   assign odd_fault = (chk_odd && (fault_vcc_ov || fault_out_ov || fault_cs_short)) || (chk_ol && fault_over_load);
   assign ns_fault  = line_ovp_active || brownout_active || fault_over_temp;

   // fixed crossing count in burst, normal gate request in normal mode, no turn-on while halted
   always_comb begin
      if (burst_mode == BM_BURST_ON) begin
         on_req = (zero_crossing_count >= ud_max);
      end else if (burst_mode == BM_NORMAL) begin
         on_req = s_nreq;
      end else begin
         on_req = 1'b0;
      end
   end

   // current limit wins over any turn-on
   always_comb begin
      gate_next = gate_on;
      if (!level_latched || ns_fault || odd_fault || fault_vcc_uv || halted) begin
         gate_next = 1'b0;
      end else if (s_cs_lim) begin
         gate_next = 1'b0;
      end else if (burst_mode == BM_BURST_ON && s_cs_blim) begin
         gate_next = 1'b0;
      end else if (!gate_on && on_req) begin
         gate_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gate_on <= 1'b0;
      end else begin
         gate_on <= gate_next;
      end
   end

   // supply-good follows the 4 V detector
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         supply_good <= 1'b0;
         s_on_d_reg  <= 1'b0;
         zc_d_reg    <= 1'b0;
      end else begin
         supply_good <= s_above_4v;
         s_on_d_reg  <= s_on;
         zc_d_reg    <= s_zc;
      end
   end

   // level latch set at turn-on; cleared while supply not good
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_latched   <= 1'b0;
         burst_level_two <= 1'b0;
      end else if (!s_above_4v) begin
         level_latched   <= 1'b0;
         burst_level_two <= 1'b0;
      end else if (s_on && !s_on_d_reg && !level_latched) begin
         level_latched   <= 1'b1;
         // level 2 when feedback below reference
         burst_level_two <= !s_fb_ref;
      end
   end

   // selection source off 2 us after turn-on
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_cnt_reg <= '0;
      end else if (!s_on || !s_above_4v) begin
         sel_cnt_reg <= '0;
      end else if (sel_cnt_reg < 5'(SEL_OFF_CYC)) begin
         sel_cnt_reg <= sel_cnt_reg + 5'h01;
      end
   end

   // pull-up swap while undetected and off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_current_en     <= 1'b1;
         feedback_pullup_en <= 1'b0;
      end else begin
         sel_current_en     <= !(s_on && s_above_4v && sel_cnt_reg >= 5'(SEL_OFF_CYC - 1));
         feedback_pullup_en <= s_on && s_above_4v && sel_cnt_reg >= 5'(SEL_OFF_CYC - 1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blank_cnt_reg <= '0;
      end else if (burst_mode != BM_NORMAL || !entry_ok) begin
         blank_cnt_reg <= '0;
      end else if (blank_cnt_reg < 25'(BLANK_CYC)) begin
         blank_cnt_reg <= blank_cnt_reg + 25'h0000001;
      end
   end

   // Burst mode state machine
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         burst_mode <= BM_NORMAL;
      end else if (!level_latched) begin
         burst_mode <= BM_NORMAL;
      end else begin
         unique case (burst_mode)
            BM_NORMAL: begin
               if (entry_ok && blank_cnt_reg >= 25'(BLANK_CYC - 1)) begin
                  burst_mode <= BM_BURST_OFF;
               end
            end
            BM_BURST_ON: begin
               if (s_fb_leave) begin
                  burst_mode <= BM_NORMAL;
               end else if (s_fb_boff) begin
                  burst_mode <= BM_BURST_OFF;
               end
            end
            BM_BURST_OFF: begin
               if (s_fb_leave) begin
                  burst_mode <= BM_NORMAL;
               end else if (s_fb_bon) begin
                  burst_mode <= BM_BURST_ON;
               end
            end
         endcase
      end
   end

   // up/down counter with clamps; load on burst exit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         updown_count <= UD_MIN_LOW;
      end else if (!level_latched || s_udr) begin
         updown_count <= ud_min;
      end else if (burst_mode != BM_NORMAL && s_fb_leave) begin
         updown_count <= ud_min;
      end else if (burst_mode == BM_NORMAL) begin
         if (updown_count < ud_min) begin
            updown_count <= ud_min;
         end else if (updown_count > ud_max) begin
            updown_count <= ud_max;
         end else if (s_up && !s_down && updown_count < ud_max) begin
            updown_count <= updown_count + 4'h1;
         end else if (s_down && !s_up && updown_count > ud_min) begin
            updown_count <= updown_count - 4'h1;
         end
      end
   end

   // crossing counter, cleared at gate high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         zero_crossing_count <= ZC_ZERO;
      end else if (gate_next && !gate_on) begin
         zero_crossing_count <= ZC_ZERO;
      end else if (!gate_on && zc_fall && zero_crossing_count < ud_max) begin
         zero_crossing_count <= zero_crossing_count + ZC_ONE;
      end
   end

   // limit and count compensation follow line level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_compensation_high <= 1'b0;
         threshold_sel          <= SEL_NORMAL;
      end else begin
         line_compensation_high <= s_hl;
         if (burst_mode == BM_NORMAL) begin
            threshold_sel <= SEL_NORMAL;
         end else begin
            threshold_sel <= burst_level_two ? SEL_BURST_TWO : SEL_BURST_ONE;
         end
      end
   end

   // line over-voltage; brownout with brown-in release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_ovp_active <= 1'b0;
         brownout_active <= 1'b0;
      end else begin
         line_ovp_active <= s_lovp;
         if (s_bo) begin
            brownout_active <= 1'b1;
         end else if (s_bi) begin
            brownout_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         protection_mode <= PROT_NONE;
      end else if (ns_fault) begin
         protection_mode <= PROT_NOSWITCH;
      end else if (odd_fault) begin
         protection_mode <= PROT_ODDSKIP;
      end else if (fault_vcc_uv) begin
         protection_mode <= PROT_RESTART;
      end else begin
         protection_mode <= PROT_NONE;
      end
   end

   property p_cs_off;
      @(posedge sys_clk) disable iff (rst) s_cs_lim |=> !gate_on;
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("gate stayed on past current limit");

   property p_latch_hold;
      @(posedge sys_clk) disable iff (rst) level_latched && s_above_4v |=> $stable(burst_level_two);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("burst level changed while latched");

   property p_sg_clear;
      @(posedge sys_clk) disable iff (rst) !s_above_4v |=> !level_latched && !supply_good;
   endproperty
   a_sg_clear: assert property (p_sg_clear) else $error("latch not cleared below 4 V");

   property p_halt_off;
      @(posedge sys_clk) disable iff (rst) halted |=> !gate_on;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("gate on while burst halted");

   property p_exit_load;
      @(posedge sys_clk) disable iff (rst)
         level_latched && !s_udr && burst_mode != BM_NORMAL && s_fb_leave |=> updown_count == $past(ud_min);
   endproperty
   a_exit_load: assert property (p_exit_load) else $error("counter not loaded on burst exit");

   property p_ud_range;
      @(posedge sys_clk) disable iff (rst) $past(level_latched) && updown_count > 4'h0 |-> updown_count <= UD_MAX_HIGH;
   endproperty
   a_ud_range: assert property (p_ud_range) else $error("up/down counter out of range");

   property p_bo_hold;
      @(posedge sys_clk) disable iff (rst) brownout_active && !s_bi && !s_bo |=> brownout_active;
   endproperty
   a_bo_hold: assert property (p_bo_hold) else $error("brownout released early");

   sequence s_entry_held;
      burst_mode == BM_NORMAL && level_latched ##1 burst_mode == BM_BURST_OFF;
   endsequence
   property p_entry_blank;
      @(posedge sys_clk) disable iff (rst) s_entry_held |-> $past(blank_cnt_reg, 2) >= 25'(BLANK_CYC - 2);
   endproperty
   a_entry_blank: assert property (p_entry_blank) else $error("burst entered before blanking");

   property p_zc_clear;
      @(posedge sys_clk) disable iff (rst) $rose(gate_on) |-> zero_crossing_count == ZC_ZERO;
   endproperty
   a_zc_clear: assert property (p_zc_clear) else $error("crossing count not cleared at gate on");
endmodule

//--- bmpc_stage.sv
// Behavioural flyback power stage seen from the controller's pins
`timescale 1ns/1ps
module bmpc_stage #(
   parameter int ON_CYC = 6,
   parameter int ZC_N   = 3
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic gate_on,
   output logic      cs_above_limit,
   output logic      cs_above_burst_limit,
   output logic      zero_cross_input
);
   int on_cnt;
   int ph;

   // Current ramps while on; ringing gives ZC_N falling crossings after turn-off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         on_cnt               <= 0;
         ph                   <= 0;
         cs_above_limit       <= 1'b0;
         cs_above_burst_limit <= 1'b0;
         zero_cross_input     <= 1'b1;
      end else if (gate_on) begin
         on_cnt               <= on_cnt + 1;
         ph                   <= 0;
         zero_cross_input     <= 1'b1;
         cs_above_limit       <= (on_cnt >= ON_CYC);
         cs_above_burst_limit <= (on_cnt >= ON_CYC / 2);
      end else begin
         on_cnt               <= 0;
         cs_above_limit       <= 1'b0;
         cs_above_burst_limit <= 1'b0;
         // Ringing dies out, so the pin settles high instead of toggling forever
         if (ph < 4 * ZC_N) begin
            ph               <= ph + 1;
            zero_cross_input <= ph[1];
         end
      end
   end
endmodule

//--- testbench.sv
// Self-checking bench for the burst mode and protection controller
`timescale 1ns/1ps
module testbench;
   import bmpc_pkg::*;
   logic sys_clk, rst, supply_above_4v, supply_on, fb_above_level_ref, fb_below_entry;
   logic fb_above_burst_on, fb_below_burst_off, fb_above_leave, cs_above_limit;
   logic cs_above_burst_limit, zero_cross_input, high_line, line_above_ovp;
   logic line_below_brownout, line_above_brownin, normal_gate_on_req, ud_up, ud_down, ud_reset;
   logic [5:0] flt;
   logic gate_on, supply_good, level_latched, burst_level_two, feedback_pullup_en;
   logic sel_current_en, line_compensation_high, line_ovp_active, brownout_active;
   logic [1:0] threshold_sel, protection_mode;
   logic [3:0] updown_count, zero_crossing_count;
   bmpc_mode_t burst_mode;
   logic [1:0] fexp [6];
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   // Short entry blanking so that burst mode is reached within the run
   localparam int BLANK = 60;

   bmpc_ctrl #(.BLANK_CYC(BLANK)) i_bmpc_ctrl (.sys_clk, .rst, .supply_above_4v, .supply_on, .fb_above_level_ref,
      .fb_below_entry, .fb_above_burst_on, .fb_below_burst_off, .fb_above_leave, .cs_above_limit,
      .cs_above_burst_limit, .zero_cross_input, .high_line, .line_above_ovp, .line_below_brownout,
      .line_above_brownin, .normal_gate_on_req, .ud_up, .ud_down, .ud_reset,
      .fault_vcc_ov(flt[0]), .fault_vcc_uv(flt[1]), .fault_over_load(flt[2]),
      .fault_out_ov(flt[3]), .fault_over_temp(flt[4]), .fault_cs_short(flt[5]),
      .gate_on, .supply_good, .level_latched, .burst_level_two, .feedback_pullup_en,
      .sel_current_en, .threshold_sel, .line_compensation_high, .updown_count,
      .zero_crossing_count, .burst_mode, .line_ovp_active, .brownout_active, .protection_mode);

   // Enough ringing to reach the largest crossing count
   bmpc_stage #(.ZC_N(10)) i_bmpc_stage (.sys_clk, .rst, .gate_on, .cs_above_limit, .cs_above_burst_limit,
      .zero_cross_input);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Run is a few hundred cycles; this only catches a hang
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         $display("[FAIL] %0t timeout", $time);
         complete_run();
      end
   end

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Inputs always change 10 ns after a rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #10;
   endtask

   task automatic power_up(input logic ref_hi);
      rst = 1'b1;
      supply_above_4v = 1'b0;
      supply_on = 1'b0;
      fb_above_level_ref = ref_hi;
      tick(6);
      rst = 1'b0;
      tick(1);
      chk_bit(level_latched, 1'h0, "latch clear");
      chk_bit(sel_current_en, 1'h1, "sel source on");
      chk_bit(feedback_pullup_en, 1'h0, "pullup off");
      supply_above_4v = 1'b1;
      tick(4);
      chk_bit(supply_good, 1'h1, "supply good");
      chk_bit(level_latched, 1'h0, "latch before on");
      supply_on = 1'b1;
      tick(4);
      chk_bit(level_latched, 1'h1, "latch set");
      chk_bit(burst_level_two, ~ref_hi, "level choice");
      fb_above_level_ref = ~ref_hi;
      tick(11);
      chk_bit(sel_current_en, 1'h1, "source before 2 us");
      tick(10);
      chk_bit(sel_current_en, 1'h0, "source after 2 us");
      chk_bit(feedback_pullup_en, 1'h1, "pullup back");
      chk_bit(burst_level_two, ~ref_hi, "level held");
   endtask

   task automatic wait_gate(input logic v);
      n = 0;
      while (gate_on !== v && n < 40) begin
         tick(1);
         n++;
      end
      chk_bit(gate_on, v, "gate level");
   endtask

   initial begin
      {fb_below_entry, fb_above_burst_on, fb_below_burst_off, fb_above_leave} = 4'h0;
      {high_line, line_above_ovp, line_below_brownout, normal_gate_on_req} = 4'h0;
      {ud_up, ud_down, ud_reset} = 3'h0;
      line_above_brownin = 1'b1;
      flt = 6'h00;
      fexp = '{PROT_ODDSKIP, PROT_RESTART, PROT_ODDSKIP, PROT_ODDSKIP, PROT_NOSWITCH, PROT_ODDSKIP};
      power_up(1'b1);
      power_up(1'b0);
      for (int hl = 1; hl >= 0; hl--) begin
         high_line = hl[0];
         ud_reset = 1'b1;
         tick(4);
         ud_reset = 1'b0;
         ud_down = 1'b1;
         tick(4);
         ud_down = 1'b0;
         tick(4);
         chk_bit(line_compensation_high, hl[0], "line comp");
         chk_val(updown_count, hl[0] ? 4'h3 : 4'h1, "ud floor");
         ud_up = 1'b1;
         fb_below_entry = 1'b1;
         tick(14);
         ud_up = 1'b0;
         tick(4);
         chk_val(updown_count, hl[0] ? 4'hA : 4'h8, "ud ceiling");
      end
      chk_val(4'(burst_mode), 4'(BM_NORMAL), "no burst before blanking");
      fb_below_entry = 1'b0;
      normal_gate_on_req = 1'b1;
      wait_gate(1'b1);
      tick(1);
      chk_val(zero_crossing_count, 4'h0, "zc cleared");
      n = 0;
      while (cs_above_limit !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      tick(3);
      chk_bit(gate_on, 1'h0, "current limit off");
      normal_gate_on_req = 1'b0;
      tick(45);
      chk_val(zero_crossing_count, UD_MAX_LOW, "zc counted");
      normal_gate_on_req = 1'b1;
      wait_gate(1'b1);
      tick(1);
      chk_val(zero_crossing_count, 4'h0, "zc cleared again");
      line_above_ovp = 1'b1;
      tick(5);
      chk_bit(line_ovp_active, 1'h1, "ovp enter");
      chk_val(4'(protection_mode), 4'(PROT_NOSWITCH), "ovp mode");
      chk_bit(gate_on, 1'h0, "ovp gate");
      line_above_ovp = 1'b0;
      tick(5);
      chk_bit(line_ovp_active, 1'h0, "ovp release");
      line_below_brownout = 1'b1;
      line_above_brownin = 1'b0;
      tick(5);
      chk_bit(brownout_active, 1'h1, "brownout enter");
      chk_val(4'(protection_mode), 4'(PROT_NOSWITCH), "brownout mode");
      line_below_brownout = 1'b0;
      tick(5);
      chk_bit(brownout_active, 1'h1, "brownout hysteresis");
      line_above_brownin = 1'b1;
      tick(5);
      chk_bit(brownout_active, 1'h0, "brown-in release");
      // every fault checked in normal mode
      for (int i = 0; i < 6; i++) begin
         flt = 6'h01 << i;
         tick(5);
         chk_val(4'(protection_mode), 4'(fexp[i]), "fault mode");
         chk_bit(gate_on, 1'h0, "fault gate");
         flt = 6'h00;
         tick(5);
      end
      // burst entry, halt, switching and exit
      normal_gate_on_req = 1'b0;
      fb_below_entry = 1'b1;
      tick(BLANK - 4);
      chk_val(4'(burst_mode), 4'(BM_NORMAL), "blanking holds normal");
      tick(8);
      chk_val(4'(burst_mode), 4'(BM_BURST_OFF), "burst entered");
      chk_val(4'(threshold_sel), 4'(SEL_BURST_TWO), "level two thresholds");
      chk_bit(gate_on, 1'h0, "entry halted");
      flt = 6'h2D;
      tick(2);
      chk_val(4'(protection_mode), 4'(PROT_NONE), "faults masked halted");
      flt = 6'h00;
      fb_above_burst_on = 1'b1;
      wait_gate(1'b1);
      chk_val(4'(burst_mode), 4'(BM_BURST_ON), "burst resume");
      fb_above_burst_on = 1'b0;
      tick(8);
      chk_bit(gate_on, 1'h0, "burst limit off");
      n = 0;
      while (zero_crossing_count !== UD_MAX_LOW && n < 60) begin
         tick(1);
         n++;
      end
      chk_bit(gate_on, 1'h0, "burst waits for crossings");
      wait_gate(1'b1);
      fb_below_burst_off = 1'b1;
      tick(4);
      chk_val(4'(burst_mode), 4'(BM_BURST_OFF), "burst halt");
      chk_bit(gate_on, 1'h0, "halt gate");
      fb_below_burst_off = 1'b0;
      fb_above_leave = 1'b1;
      tick(4);
      chk_val(4'(burst_mode), 4'(BM_NORMAL), "burst leave");
      chk_val(updown_count, UD_MIN_LOW, "exit load");
      chk_val(4'(threshold_sel), 4'(SEL_NORMAL), "normal thresholds");
      fb_above_leave = 1'b0;
      normal_gate_on_req = 1'b1;
      wait_gate(1'b1);
      supply_above_4v = 1'b0;
      tick(5);
      chk_bit(supply_good, 1'h0, "supply low");
      chk_bit(level_latched, 1'h0, "latch cleared");
      complete_run();
   end
endmodule
